// ### psdl_pkg.sv
package psdl_pkg;

    // ----------------------------------------------------------------
    // Strap vector layout
    // ----------------------------------------------------------------
    localparam int STRAP_W = 8;
    localparam int LATCH_W = 7;
    localparam int IDX_P2_SPEED = 0;
    localparam int IDX_P2_DUPLEX = 1;
    localparam int IDX_P2_BP = 2;
    localparam int IDX_P2_PAUSE = 3;
    localparam int IDX_P2_FLOWSEL = 4;
    localparam int IDX_P0_SPEED = 5;
    localparam int IDX_P0_DPX_POL = 6;
    localparam int IDX_P0_DUPLEX_PIN = 7;

    // Pins are pulled high, so idle level is one
    localparam logic [STRAP_W-1:0] STRAP_RESET = 8'hff;
    localparam logic [LATCH_W-1:0] LATCH_RESET = 7'h7f;

    // ----------------------------------------------------------------
    // Settle timing after reset release
    // ----------------------------------------------------------------
    localparam int SETTLE_W = 3;
    localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 3'h0;
    localparam logic [SETTLE_W-1:0] SETTLE_ONE = 3'h1;
    localparam logic [SETTLE_W-1:0] SETTLE_LAST = 3'h4;

    // ----------------------------------------------------------------
    // Link partner base page ability
    // ----------------------------------------------------------------
    localparam int ABIL_W = 16;
    localparam logic [ABIL_W-1:0] ABIL_BASE = 16'h0001;
    localparam int ABIL_10HD_BIT = 5;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        PSDL_ST_SETTLE = 1'b0,
        PSDL_ST_RUN = 1'b1
    } psdl_state_t;

    typedef struct packed {
        logic rate_select_low_bit;
        logic dpx_mode_bit;
        logic p2_backpressure_enable;
        logic p2_tx_pause_enable;
        logic p2_rx_pause_enable;
        logic p2_manual_flowctl;
    } psdl_p2_cfg_t;

    localparam psdl_p2_cfg_t P2_CFG_RESET = 6'h3f;

endpackage

// ### psdl_strap_if.sv
`timescale 1ns/100ps
interface psdl_strap_if;
    import psdl_pkg::*;

    logic [STRAP_W-1:0] raw;
    logic [STRAP_W-1:0] clean;

    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// ### psdl_strap_sync.sv
`timescale 1ns/100ps
module psdl_strap_sync (
    input wire logic clk_sys,
    input wire logic reset_n,
    psdl_strap_if.sync strap
);
    import psdl_pkg::*;

    // ----------------------------------------------------------------
    // Three stage synchroniser per pin, change taken when the second and third stages agree
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < STRAP_W; gi++) begin : g_bit
            logic s1_reg, s2_reg, s3_reg, clean_reg;
            logic s1_next, s2_next, s3_next, clean_next;

            always_comb begin
                s1_next = strap.raw[gi];
                s2_next = s1_reg;
                s3_next = s2_reg;
                clean_next = (s2_reg == s3_reg) ? s3_reg : clean_reg;
            end

            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    s1_reg <= STRAP_RESET[gi];
                    s2_reg <= STRAP_RESET[gi];
                    s3_reg <= STRAP_RESET[gi];
                    clean_reg <= STRAP_RESET[gi];
                end else begin
                    s1_reg <= s1_next;
                    s2_reg <= s2_next;
                    s3_reg <= s3_next;
                    clean_reg <= clean_next;
                end
            end

            assign strap.clean[gi] = clean_reg;
        end
    endgenerate

endmodule

// ### psdl_port_strap_default_latch.sv
`timescale 1ns/100ps
// Operation
// RQ1 - Port 2 speed bit default from strap: low 10 Mbps, high 100 Mbps.
// RQ2 - Port 2 duplex bit default from strap: low half, high full duplex.
// RQ3 - Port 2 backpressure enable default follows the backpressure strap.
// RQ4 - One strap sets both port 2 pause transmit and receive enables.
// RQ5 - Manual select strap: low follows autonegotiation, high follows pause enables.
// RQ6 - Port 0 speed, polarity strap and duplex pin form partner ability.
// RQ7 - On failed virtual autonegotiation port 0 runs at strapped speed.
// RQ8 - Port 0 full duplex when duplex pin equals latched polarity strap.
// RQ9 - Straps sampled at power-on and at every reset release.
// RQ10 - EEPROM loader may replace latched defaults afterwards.
// RQ11 - Latched straps hold between resets; software writes change the bits.
module psdl_port_strap_default_latch (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic p2_speed_strap,
    input wire logic p2_duplex_strap,
    input wire logic p2_backpressure_strap,
    input wire logic p2_pause_strap,
    input wire logic p2_flowctl_select_strap,
    input wire logic p0_speed_strap,
    input wire logic p0_dpx_polarity_strap,
    input wire logic p0_duplex_pin,
    input wire logic eeprom_load,
    input wire psdl_pkg::psdl_p2_cfg_t eeprom_p2_cfg,
    input wire logic sw_write_phy,
    input wire logic sw_write_flowctl,
    input wire psdl_pkg::psdl_p2_cfg_t sw_p2_cfg,
    input wire logic p2_an_tx_pause,
    input wire logic p2_an_rx_pause,
    input wire logic p0_an_failed,
    input wire logic p0_an_speed_100,
    output logic straps_valid,
    output logic [psdl_pkg::LATCH_W-1:0] latched_straps,
    output psdl_pkg::psdl_p2_cfg_t p2_phy_basic_control,
    output logic p2_tx_pause_active,
    output logic p2_rx_pause_active,
    output logic [psdl_pkg::ABIL_W-1:0] virtual_partner_base_ability,
    output logic p0_speed_100,
    output logic p0_full_duplex
);
    import psdl_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    psdl_strap_if strap_bus ();

    assign strap_bus.raw = {p0_duplex_pin, p0_dpx_polarity_strap, p0_speed_strap,
        p2_flowctl_select_strap, p2_pause_strap, p2_backpressure_strap,
        p2_duplex_strap, p2_speed_strap};

    psdl_strap_sync u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .strap (strap_bus.sync)
    );

    logic [STRAP_W-1:0] pins;
    assign pins = strap_bus.clean;

    // ----------------------------------------------------------------
    // Latch sequencer and strap capture
    // ----------------------------------------------------------------
    psdl_state_t state_reg, state_next;
    logic [SETTLE_W-1:0] cnt_reg, cnt_next;
    logic [LATCH_W-1:0] strap_reg, strap_next;
    logic valid_reg, valid_next;
    logic latch_now;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        strap_next = strap_reg;
        valid_next = valid_reg;
        latch_now = 1'b0;
        case (state_reg)
            PSDL_ST_SETTLE: begin
                // Wait for synchronised pins to reflect the board
                if (cnt_reg == SETTLE_LAST) begin
                    latch_now = 1'b1;
                    strap_next = pins[LATCH_W-1:0]; // RQ9
                    valid_next = 1'b1;
                    state_next = PSDL_ST_RUN;
                end else begin
                    cnt_next = cnt_reg + SETTLE_ONE;
                end
            end
            PSDL_ST_RUN: begin
                strap_next = strap_reg; // RQ11
            end
            default: begin
                state_next = PSDL_ST_SETTLE;
                cnt_next = SETTLE_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_reg <= PSDL_ST_SETTLE;
            cnt_reg <= SETTLE_ZERO;
            strap_reg <= LATCH_RESET;
            valid_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            strap_reg <= strap_next;
            valid_reg <= valid_next;
        end
    end

    // ----------------------------------------------------------------
    // Control bits and port 0 status
    // ----------------------------------------------------------------
    psdl_p2_cfg_t cfg_reg, cfg_next;
    logic txa_reg, txa_next;
    logic rxa_reg, rxa_next;
    logic [ABIL_W-1:0] abil_reg, abil_next;
    logic spd_reg, spd_next;
    logic fdx_reg, fdx_next;
    logic pin_full;

    always_comb begin
        cfg_next = cfg_reg;
        pin_full = (pins[IDX_P0_DUPLEX_PIN] == strap_reg[IDX_P0_DPX_POL]); // RQ8
        if (latch_now) begin
            cfg_next.rate_select_low_bit = pins[IDX_P2_SPEED]; // RQ1
            cfg_next.dpx_mode_bit = pins[IDX_P2_DUPLEX]; // RQ2
            cfg_next.p2_backpressure_enable = pins[IDX_P2_BP]; // RQ3
            cfg_next.p2_tx_pause_enable = pins[IDX_P2_PAUSE]; // RQ4
            cfg_next.p2_rx_pause_enable = pins[IDX_P2_PAUSE]; // RQ4
            cfg_next.p2_manual_flowctl = pins[IDX_P2_FLOWSEL]; // RQ5
        end else if (valid_reg) begin
            if (sw_write_phy) begin
                cfg_next.rate_select_low_bit = sw_p2_cfg.rate_select_low_bit; // RQ11
                cfg_next.dpx_mode_bit = sw_p2_cfg.dpx_mode_bit;
            end
            if (sw_write_flowctl) begin
                cfg_next.p2_backpressure_enable = sw_p2_cfg.p2_backpressure_enable; // RQ11
                cfg_next.p2_tx_pause_enable = sw_p2_cfg.p2_tx_pause_enable;
                cfg_next.p2_rx_pause_enable = sw_p2_cfg.p2_rx_pause_enable;
                cfg_next.p2_manual_flowctl = sw_p2_cfg.p2_manual_flowctl;
            end
            // Loader overrides a same-cycle software write
            if (eeprom_load) begin
                cfg_next = eeprom_p2_cfg; // RQ10
            end
        end
        // Pause follows autonegotiation unless manual select is set
        txa_next = cfg_reg.p2_manual_flowctl ? cfg_reg.p2_tx_pause_enable
                                             : p2_an_tx_pause; // RQ5
        rxa_next = cfg_reg.p2_manual_flowctl ? cfg_reg.p2_rx_pause_enable
                                             : p2_an_rx_pause; // RQ5
        abil_next = ABIL_BASE;
        abil_next[ABIL_10HD_BIT + {strap_reg[IDX_P0_SPEED], pin_full}] = 1'b1; // RQ6
        spd_next = p0_an_failed ? strap_reg[IDX_P0_SPEED] : p0_an_speed_100; // RQ7
        fdx_next = pin_full; // RQ8
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cfg_reg <= P2_CFG_RESET;
            txa_reg <= 1'b0;
            rxa_reg <= 1'b0;
            abil_reg <= ABIL_BASE;
            spd_reg <= 1'b0;
            fdx_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            txa_reg <= txa_next;
            rxa_reg <= rxa_next;
            abil_reg <= abil_next;
            spd_reg <= spd_next;
            fdx_reg <= fdx_next;
        end
    end

    assign straps_valid = valid_reg;
    assign latched_straps = strap_reg;
    assign p2_phy_basic_control = cfg_reg;
    assign p2_tx_pause_active = txa_reg;
    assign p2_rx_pause_active = rxa_reg;
    assign virtual_partner_base_ability = abil_reg;
    assign p0_speed_100 = spd_reg;
    assign p0_full_duplex = fdx_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_release;
        $rose(reset_n);
    endsequence

    sequence s_settle_then_valid;
        !straps_valid [*5] ##1 straps_valid;
    endsequence

    a_latch_after_release: assert property (@(posedge clk_sys) // RQ9
        s_release |-> s_settle_then_valid)
        else $error("straps not latched five cycles after reset release");

    a_p2_rate_default: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ1
        $rose(straps_valid) |-> p2_phy_basic_control.rate_select_low_bit
            == latched_straps[IDX_P2_SPEED])
        else $error("port 2 speed default differs from strap");

    a_p2_dpx_default: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ2
        $rose(straps_valid) |-> p2_phy_basic_control.dpx_mode_bit
            == latched_straps[IDX_P2_DUPLEX])
        else $error("port 2 duplex default differs from strap");

    a_p2_bp_default: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ3
        $rose(straps_valid) |-> p2_phy_basic_control.p2_backpressure_enable
            == latched_straps[IDX_P2_BP])
        else $error("port 2 backpressure default differs from strap");

    a_p2_pause_default: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ4
        $rose(straps_valid) |->
            p2_phy_basic_control.p2_tx_pause_enable == latched_straps[IDX_P2_PAUSE] &&
            p2_phy_basic_control.p2_rx_pause_enable == latched_straps[IDX_P2_PAUSE])
        else $error("port 2 pause defaults differ from strap");

    a_p2_pause_select: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ5
        $past(reset_n) |-> p2_tx_pause_active == ($past(cfg_reg.p2_manual_flowctl)
            ? $past(cfg_reg.p2_tx_pause_enable) : $past(p2_an_tx_pause)))
        else $error("port 2 pause source selection wrong");

    a_p0_ability_bits: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ6
        $past(reset_n) |-> virtual_partner_base_ability == (ABIL_BASE | (16'h0001
            << (ABIL_10HD_BIT + 2 * $past(strap_reg[IDX_P0_SPEED]) + $past(pin_full)))))
        else $error("partner ability does not match strapped mode");

    a_p0_fallback_speed: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ7
        $past(reset_n) && $past(p0_an_failed) |->
            p0_speed_100 == $past(strap_reg[IDX_P0_SPEED]))
        else $error("port 0 fallback speed differs from strap");

    a_p0_duplex_compare: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ8
        $past(reset_n) |-> p0_full_duplex ==
            ($past(pins[IDX_P0_DUPLEX_PIN]) == $past(strap_reg[IDX_P0_DPX_POL])))
        else $error("port 0 duplex compare wrong");

    a_eeprom_override: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ10
        straps_valid && eeprom_load |=> p2_phy_basic_control == $past(eeprom_p2_cfg))
        else $error("loader value not applied");

    a_straps_held: assert property (@(posedge clk_sys) disable iff (!reset_n) // RQ11
        straps_valid && $past(straps_valid) |-> $stable(latched_straps))
        else $error("latched straps changed between resets");

endmodule

// ### psdl_strap_pull.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Board strap resistors
// ----------------------------------------------------------------
// Every pin idles high through its pull-up; a fitted pull-down wins
module psdl_strap_pull (
    input wire logic [psdl_pkg::STRAP_W-1:0] pull_down,
    output logic [psdl_pkg::STRAP_W-1:0] pins
);
    import psdl_pkg::*;

    assign pins = ~pull_down;
endmodule

// ### tb_port_strap_default_latch.sv
`timescale 1ns/100ps
module tb_port_strap_default_latch;
    import psdl_pkg::*;

    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [STRAP_W-1:0] board_low = 8'h00;
    logic [STRAP_W-1:0] pins;
    logic eeprom_load = 1'b0;
    logic sw_write_phy = 1'b0;
    logic sw_write_flowctl = 1'b0;
    psdl_p2_cfg_t eeprom_p2_cfg = 6'h00;
    psdl_p2_cfg_t sw_p2_cfg = 6'h00;
    logic an_tx = 1'b0;
    logic an_rx = 1'b0;
    logic an_failed = 1'b0;
    logic an_speed_100 = 1'b0;
    logic straps_valid;
    logic [LATCH_W-1:0] latched_straps;
    psdl_p2_cfg_t p2_cfg;
    logic tx_active;
    logic rx_active;
    logic [ABIL_W-1:0] ability;
    logic p0_speed_100;
    logic p0_full_duplex;
    int fails = 0;
    int samples_checked = 0;

    psdl_strap_pull PULL (.pull_down(board_low), .pins(pins));

    psdl_port_strap_default_latch DUT (
        .clk_sys(clk_sys), .reset_n(reset_n),
        .p2_speed_strap(pins[IDX_P2_SPEED]), .p2_duplex_strap(pins[IDX_P2_DUPLEX]),
        .p2_backpressure_strap(pins[IDX_P2_BP]), .p2_pause_strap(pins[IDX_P2_PAUSE]),
        .p2_flowctl_select_strap(pins[IDX_P2_FLOWSEL]), .p0_speed_strap(pins[IDX_P0_SPEED]),
        .p0_dpx_polarity_strap(pins[IDX_P0_DPX_POL]), .p0_duplex_pin(pins[IDX_P0_DUPLEX_PIN]),
        .eeprom_load(eeprom_load), .eeprom_p2_cfg(eeprom_p2_cfg),
        .sw_write_phy(sw_write_phy), .sw_write_flowctl(sw_write_flowctl),
        .sw_p2_cfg(sw_p2_cfg), .p2_an_tx_pause(an_tx), .p2_an_rx_pause(an_rx),
        .p0_an_failed(an_failed), .p0_an_speed_100(an_speed_100),
        .straps_valid(straps_valid), .latched_straps(latched_straps),
        .p2_phy_basic_control(p2_cfg), .p2_tx_pause_active(tx_active),
        .p2_rx_pause_active(rx_active), .virtual_partner_base_ability(ability),
        .p0_speed_100(p0_speed_100), .p0_full_duplex(p0_full_duplex)
    );

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic pulse(input logic phy, input logic flow, input logic load,
                         input psdl_p2_cfg_t sw, input psdl_p2_cfg_t ee);
        @(posedge clk_sys);
        sw_write_phy <= phy;
        sw_write_flowctl <= flow;
        eeprom_load <= load;
        sw_p2_cfg <= sw;
        eeprom_p2_cfg <= ee;
        @(posedge clk_sys);
        sw_write_phy <= 1'b0;
        sw_write_flowctl <= 1'b0;
        eeprom_load <= 1'b0;
        #1;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic restart(input logic [STRAP_W-1:0] low);
        logic [STRAP_W-1:0] s;
        s = ~low;
        @(posedge clk_sys);
        reset_n <= 1'b0;
        board_low <= low;
        repeat (20) @(posedge clk_sys);
        #1;
        check("cfg_in_reset", p2_cfg, P2_CFG_RESET);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        check("valid_early", straps_valid, 1'b0);
        @(posedge clk_sys);
        #1;
        check("valid", straps_valid, 1'b1);
        check("latched", latched_straps, s[LATCH_W-1:0]);
        check("rate", p2_cfg.rate_select_low_bit, s[IDX_P2_SPEED]);
        check("dpx", p2_cfg.dpx_mode_bit, s[IDX_P2_DUPLEX]);
        check("bp", p2_cfg.p2_backpressure_enable, s[IDX_P2_BP]);
        check("tx_en", p2_cfg.p2_tx_pause_enable, s[IDX_P2_PAUSE]);
        check("rx_en", p2_cfg.p2_rx_pause_enable, s[IDX_P2_PAUSE]);
        check("manual", p2_cfg.p2_manual_flowctl, s[IDX_P2_FLOWSEL]);
    endtask

    task automatic hold_and_write();
        restart(8'h00);
        @(posedge clk_sys);
        board_low <= 8'h7f;
        repeat (8) @(posedge clk_sys);
        #1;
        check("held", latched_straps, 7'h7f);
        pulse(1'b1, 1'b0, 1'b0, 6'h00, 6'h00);
        check("sw_phy", p2_cfg, 6'h0f);
        pulse(1'b0, 1'b1, 1'b0, 6'h3a, 6'h00);
        check("sw_flow", p2_cfg, 6'h0a);
        pulse(1'b1, 1'b1, 1'b1, 6'h3f, 6'h15);
        check("eeprom", p2_cfg, 6'h15);
    endtask

    task automatic pause_select();
        @(posedge clk_sys);
        an_tx <= 1'b0;
        an_rx <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check("tx_manual", tx_active, 1'b1);
        check("rx_manual", rx_active, 1'b0);
        pulse(1'b0, 1'b1, 1'b0, 6'h02, 6'h00);
        @(posedge clk_sys);
        an_tx <= 1'b1;
        an_rx <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check("tx_auto", tx_active, 1'b1);
        check("rx_auto", rx_active, 1'b0);
    endtask

    task automatic port0_modes();
        logic spd;
        logic pol;
        logic pin;
        logic eq;
        for (int m = 0; m < 4; m++) begin
            spd = m[0];
            pol = m[1];
            restart({1'b0, ~pol, ~spd, (spd ? 5'h15 : 5'h0a) ^ {5{pol}}});
            for (int p = 0; p < 2; p++) begin
                pin = p[0];
                eq = (pin == pol);
                @(posedge clk_sys);
                board_low[IDX_P0_DUPLEX_PIN] <= ~pin;
                an_failed <= 1'b1;
                an_speed_100 <= ~spd;
                repeat (8) @(posedge clk_sys);
                #1;
                check("full_dpx", p0_full_duplex, eq);
                check("ability", ability, ABIL_BASE | (16'h0001 << (5 + 2 * spd + eq)));
                check("fallback", p0_speed_100, spd);
                @(posedge clk_sys);
                an_failed <= 1'b0;
                repeat (2) @(posedge clk_sys);
                #1;
                check("an_speed", p0_speed_100, !spd);
            end
        end
    endtask

    initial begin
        #200000;
        fails++;
        test_done();
    end

    initial begin
        hold_and_write();
        pause_select();
        port0_modes();
        test_done();
    end
endmodule
